//--- ctr_regs.svh
// Purpose: register map, field positions, reset values and timing figures
// Assumes: byte addresses on a 32-bit register bus
// Notes: definitions only
`ifndef CTR_REGS_SVH
`define CTR_REGS_SVH
// ****************************************
// Register offsets
// ****************************************
`define CTR_OFS_CTRL 5'h00
`define CTR_OFS_LEVELS 5'h04
`define CTR_OFS_TIMING 5'h08
`define CTR_OFS_STATUS 5'h0c
`define CTR_OFS_MADDR 5'h10
`define CTR_OFS_MDATA 5'h14
`define CTR_OFS_CMD 5'h18
// ****************************************
// Field positions
// ****************************************
`define CTR_C_FULL 1:0
`define CTR_C_PER 5:2
`define CTR_C_ACQ 7:6
`define CTR_C_ICH 8
`define CTR_C_ILVL 9
`define CTR_C_TEN 10
`define CTR_C_ACT 11
`define CTR_C_OCH 12
`define CTR_C_OPULSE 13
`define CTR_C_COND 15:14
`define CTR_C_QEN 16
`define CTR_C_QWITHIN 17
`define CTR_C_RUN 18
`define CTR_L_LO 15:0
`define CTR_L_HI 31:16
`define CTR_T_PW 15:0
`define CTR_T_QCNT 31:16
`define CTR_S_FULL 16
`define CTR_S_REC 17
`define CTR_S_HALT 18
`define CTR_S_FIRED 19
`define CTR_K_RESTART 0
`define CTR_K_CLRFIRED 1
// ****************************************
// Reset values
// ****************************************
`define CTR_CTRL_RST 32'h0000_000c
`define CTR_LEVELS_RST 32'h0000_0000
`define CTR_TIMING_RST 32'h0000_0001
// ****************************************
// Timing
// ****************************************
`define CTR_CLK_NS 100
`define CTR_US_NS 1000
`define CTR_P0_US 1
`define CTR_P1_US 2
`define CTR_P2_US 5
`define CTR_P3_US 10
`define CTR_P4_US 20
`define CTR_P5_US 50
`define CTR_P6_US 100
`define CTR_P7_US 200
`define CTR_P8_US 500
`define CTR_P9_US 1000
`endif

//--- ctr_pkg.sv
// Purpose: mode and state types of the current trigger recorder
// Assumes: nothing
// Notes: encodings match the control register fields
package ctr_pkg;
  typedef enum logic [1:0] {FULL_WRAP = 2'h0, FULL_STOP = 2'h1, FULL_HALT = 2'h2} ctr_full_t;
  typedef enum logic [1:0] {ACQ_ALL = 2'h0, ACQ_EXT = 2'h1, ACQ_MON = 2'h2} ctr_acq_t;
  typedef enum logic [1:0] {
    CND_OVER = 2'h0, CND_UNDER = 2'h1, CND_IN = 2'h2, CND_OUT = 2'h3
  } ctr_cond_t;
  typedef enum logic [1:0] {REC_IDLE = 2'h0, REC_RUN = 2'h1, REC_STOP = 2'h3} ctr_rec_t;
endpackage

//--- ctr_recorder.sv
// Purpose: supply-current sampler, gated recorder and current trigger unit
// Assumes: cur_value is a synchronous microampere reading; 10 MHz mclk
// Notes: registers on an Avalon-MM slave with one wait cycle
// Operation
// - Wrap mode overwrites from start, keeps running
// - Stop mode ends recording, target keeps running
// - Halt mode ends recording and halts target
// - Ten selectable sampling periods, 1us to 1ms
// - Unconditional acquisition stores every sample
// - External gating stores only while input detected
// - Gating input channel and active level selectable
// - Monitor gating stores between start and end
// - Disabled trigger unit detects and acts never
// - Halt action stops target on trigger
// - Output action drives one of two channels
// - Output is single pulse or held level
// - Pulse width programmable 1 to 65535 us
// - Over mode fires when current reaches threshold
// - Under mode fires when current drops to threshold
// - In-range mode fires on entering range
// - Out-of-range mode fires on leaving range
// - Thresholds in microamps, one or two values
// - Optional duration qualifier except in out-of-range mode, else fire immediately
// - Qualifier: at least interval, or within interval
// - Interval counts sampling periods
`timescale 1ns/1ps
`default_nettype none
`include "ctr_regs.svh"
module ctr_recorder #(
  parameter int DEPTH = 1024,
  parameter int SW = 16,
  parameter int CYC_PER_US = `CTR_US_NS / `CTR_CLK_NS
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Current sensor
  input wire logic [SW-1:0] cur_value,
  output logic sample_strobe,
  // Target and external triggers
  input wire logic [1:0] ext_trig_in,
  input wire logic mon_start,
  input wire logic mon_end,
  output logic target_halt,
  output logic [1:0] ext_trig_out
);
  localparam int AW = $clog2(DEPTH);

  // Refuse sizes the logic cannot serve
  if (DEPTH < 2 || DEPTH > 65536 || (1 << AW) != DEPTH || SW < 1 || SW > 16
      || CYC_PER_US < 1) begin : g_bad_param
    $error("ctr_recorder: unsupported parameter value");
  end

  // ****************************************
  // Helpers
  // ****************************************
  // Sampling period in clock cycles
  function automatic logic [31:0] period_cyc(input logic [3:0] sel);
    int us;
    case (sel)
      4'h0: us = `CTR_P0_US;
      4'h1: us = `CTR_P1_US;
      4'h2: us = `CTR_P2_US;
      4'h3: us = `CTR_P3_US;
      4'h4: us = `CTR_P4_US;
      4'h5: us = `CTR_P5_US;
      4'h6: us = `CTR_P6_US;
      4'h7: us = `CTR_P7_US;
      4'h8: us = `CTR_P8_US;
      default: us = `CTR_P9_US;
    endcase
    return 32'(us * CYC_PER_US);
  endfunction

  function automatic logic in_range(input logic [15:0] v, lo, hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] be_merge(input logic [31:0] old, wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction

  // ****************************************
  // Register bus
  // ****************************************
  logic wait_reg, wait_next;
  logic [31:0] rd_reg, rd_next, rd_mux;
  logic [31:0] ctrl_reg, ctrl_next, lev_reg, lev_next, tim_reg, tim_next;
  logic [AW-1:0] maddr_reg, maddr_next;
  logic bus_wr, do_restart, do_clrfired;
  logic [SW-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
  logic full_reg, full_next, halt_reg, halt_next, fired_reg, fired_next;
  ctr_pkg::ctr_rec_t rec_state_reg, rec_state_next;

  // Write lands on the edge where waitrequest is seen low
  assign bus_wr = avs_write && !wait_reg;
  assign do_restart = bus_wr && avs_address == `CTR_OFS_CMD
                      && avs_byteenable[0] && avs_writedata[`CTR_K_RESTART];
  assign do_clrfired = bus_wr && avs_address == `CTR_OFS_CMD
                       && avs_byteenable[0] && avs_writedata[`CTR_K_CLRFIRED];

  // Read data mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `CTR_OFS_CTRL: rd_mux = ctrl_reg;
      `CTR_OFS_LEVELS: rd_mux = lev_reg;
      `CTR_OFS_TIMING: rd_mux = tim_reg;
      `CTR_OFS_STATUS: begin
        rd_mux[15:0] = 16'(wr_ptr_reg);
        rd_mux[`CTR_S_FULL] = full_reg;
        rd_mux[`CTR_S_REC] = rec_state_reg == ctr_pkg::REC_RUN;
        rd_mux[`CTR_S_HALT] = halt_reg;
        rd_mux[`CTR_S_FIRED] = fired_reg;
      end
      `CTR_OFS_MADDR: rd_mux[15:0] = 16'(maddr_reg);
      `CTR_OFS_MDATA: rd_mux[15:0] = 16'(mem[maddr_reg]);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait cycle, then one cycle of waitrequest low
  always_comb begin
    wait_next = 1'b1;
    rd_next = rd_reg;
    ctrl_next = ctrl_reg;
    lev_next = lev_reg;
    tim_next = tim_reg;
    maddr_next = maddr_reg;
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next = 1'b0;
      rd_next = avs_read ? rd_mux : 32'h0000_0000;
    end
    if (bus_wr) begin
      case (avs_address)
        `CTR_OFS_CTRL: ctrl_next = be_merge(ctrl_reg, avs_writedata, avs_byteenable);
        `CTR_OFS_LEVELS: lev_next = be_merge(lev_reg, avs_writedata, avs_byteenable);
        `CTR_OFS_TIMING: tim_next = be_merge(tim_reg, avs_writedata, avs_byteenable);
        `CTR_OFS_MADDR: maddr_next = AW'(be_merge(32'(maddr_reg), avs_writedata,
                                                  avs_byteenable));
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wait_reg <= 1'b1;
      rd_reg <= 32'h0000_0000;
      ctrl_reg <= `CTR_CTRL_RST;
      lev_reg <= `CTR_LEVELS_RST;
      tim_reg <= `CTR_TIMING_RST;
      maddr_reg <= '0;
    end else if (clk_en) begin
      wait_reg <= wait_next;
      rd_reg <= rd_next;
      ctrl_reg <= ctrl_next;
      lev_reg <= lev_next;
      tim_reg <= tim_next;
      maddr_reg <= maddr_next;
    end
  end
  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rd_reg;

  // Configuration fields
  logic cfg_run, cfg_ten, cfg_act_out, cfg_pulse, cfg_qen, cfg_qwithin;
  logic [1:0] cfg_full, cfg_acq, cfg_cond;
  logic [15:0] cfg_lo, cfg_hi, cfg_pw, cfg_qcnt;
  assign cfg_run = ctrl_reg[`CTR_C_RUN];
  assign cfg_ten = ctrl_reg[`CTR_C_TEN];
  assign cfg_act_out = ctrl_reg[`CTR_C_ACT];
  assign cfg_pulse = ctrl_reg[`CTR_C_OPULSE];
  assign cfg_qen = ctrl_reg[`CTR_C_QEN];
  assign cfg_qwithin = ctrl_reg[`CTR_C_QWITHIN];
  assign cfg_full = ctrl_reg[`CTR_C_FULL];
  assign cfg_acq = ctrl_reg[`CTR_C_ACQ];
  assign cfg_cond = ctrl_reg[`CTR_C_COND];
  assign cfg_lo = lev_reg[`CTR_L_LO];
  assign cfg_hi = lev_reg[`CTR_L_HI];
  assign cfg_pw = tim_reg[`CTR_T_PW];
  assign cfg_qcnt = tim_reg[`CTR_T_QCNT];

  // ****************************************
  // Sampler
  // ****************************************
  logic [31:0] per_cnt_reg, per_cnt_next;
  logic stb_reg, stb_next;
  logic [15:0] smp_reg, smp_next;

  // Capture on period expiry; evaluation follows one cycle later
  always_comb begin
    per_cnt_next = per_cnt_reg;
    stb_next = 1'b0;
    smp_next = smp_reg;
    if (!cfg_run) begin
      per_cnt_next = 32'h0000_0000;
    end else if (per_cnt_reg == 32'h0000_0000) begin
      per_cnt_next = period_cyc(ctrl_reg[`CTR_C_PER]) - 32'h0000_0001;
      stb_next = 1'b1;
      smp_next = 16'(cur_value);
    end else begin
      per_cnt_next = per_cnt_reg - 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      per_cnt_reg <= 32'h0000_0000;
      stb_reg <= 1'b0;
      smp_reg <= 16'h0000;
    end else if (clk_en) begin
      per_cnt_reg <= per_cnt_next;
      stb_reg <= stb_next;
      smp_reg <= smp_next;
    end
  end
  assign sample_strobe = stb_reg;

  // ****************************************
  // Trigger unit
  // ****************************************
  logic sat, prev_sat_reg, prev_sat_next, fire, hold_reg, hold_next;
  logic [16:0] run_reg, run_next, run_inc;
  logic [31:0] pulse_reg, pulse_next;
  logic och_reg, och_next;
  logic [1:0] tout_reg, tout_next;

  // Condition on the newly captured sample
  always_comb begin
    unique case (cfg_cond)
      ctr_pkg::CND_OVER: sat = smp_reg >= cfg_lo;
      ctr_pkg::CND_UNDER: sat = smp_reg <= cfg_lo;
      ctr_pkg::CND_IN: sat = in_range(smp_reg, cfg_lo, cfg_hi);
      ctr_pkg::CND_OUT: sat = !in_range(smp_reg, cfg_lo, cfg_hi);
    endcase
  end

  // Detection, duration qualifier and output shaping
  always_comb begin
    prev_sat_next = prev_sat_reg;
    run_next = run_reg;
    run_inc = (run_reg == 17'h1ffff) ? run_reg : run_reg + 17'h00001;
    fire = 1'b0;
    if (stb_reg) begin
      prev_sat_next = sat;
      run_next = sat ? run_inc : 17'h00000;
      if (cfg_qen && cfg_cond != ctr_pkg::CND_OUT) begin
        if (!cfg_qwithin) fire = sat && run_inc == 17'(cfg_qcnt);
        else fire = !sat && prev_sat_reg && run_reg <= 17'(cfg_qcnt);
      end else begin
        fire = sat && !prev_sat_reg;
      end
      fire = fire && cfg_ten;
    end
    och_next = och_reg;
    pulse_next = (pulse_reg != 32'h0000_0000) ? pulse_reg - 32'h0000_0001 : pulse_reg;
    hold_next = hold_reg && !(stb_reg && !sat);
    if (fire && cfg_act_out) begin
      och_next = ctrl_reg[`CTR_C_OCH];
      if (cfg_pulse) pulse_next = 32'(cfg_pw == 16'h0000 ? 16'h0001 : cfg_pw)
                                  * 32'(CYC_PER_US);
      else hold_next = 1'b1;
    end
    if (!cfg_ten) begin
      pulse_next = 32'h0000_0000;
      hold_next = 1'b0;
    end
    tout_next = 2'b00;
    tout_next[och_next] = pulse_next != 32'h0000_0000 || hold_next;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      prev_sat_reg <= 1'b0;
      run_reg <= 17'h00000;
      pulse_reg <= 32'h0000_0000;
      hold_reg <= 1'b0;
      och_reg <= 1'b0;
      tout_reg <= 2'b00;
    end else if (clk_en) begin
      prev_sat_reg <= prev_sat_next;
      run_reg <= run_next;
      pulse_reg <= pulse_next;
      hold_reg <= hold_next;
      och_reg <= och_next;
      tout_reg <= tout_next;
    end
  end
  assign ext_trig_out = tout_reg;

  // ****************************************
  // Recorder
  // ****************************************
  logic mon_win_reg, mon_win_next, gate, rec_write, ptr_last;

  // Acquisition gate
  always_comb begin
    unique case (cfg_acq)
      ctr_pkg::ACQ_ALL: gate = 1'b1;
      ctr_pkg::ACQ_EXT: gate = ext_trig_in[ctrl_reg[`CTR_C_ICH]]
                               == ctrl_reg[`CTR_C_ILVL];
      ctr_pkg::ACQ_MON: gate = mon_win_reg;
      default: gate = 1'b0;
    endcase
  end
  assign rec_write = stb_reg && rec_state_reg == ctr_pkg::REC_RUN && gate;
  assign ptr_last = wr_ptr_reg == AW'(DEPTH - 1);

  // Recording state, full handling and halt request
  always_comb begin
    rec_state_next = rec_state_reg;
    wr_ptr_next = wr_ptr_reg;
    full_next = full_reg;
    halt_next = halt_reg;
    mon_win_next = (mon_win_reg || mon_start) && !mon_end;
    fired_next = (fired_reg && !do_clrfired) || fire; // Set wins over clear
    unique case (rec_state_reg)
      ctr_pkg::REC_IDLE: if (cfg_run) rec_state_next = ctr_pkg::REC_RUN;
      ctr_pkg::REC_RUN: begin
        if (!cfg_run) rec_state_next = ctr_pkg::REC_IDLE;
        if (rec_write) begin
          wr_ptr_next = wr_ptr_reg + AW'(1);
          if (ptr_last) begin
            full_next = 1'b1;
            if (cfg_full == ctr_pkg::FULL_WRAP) wr_ptr_next = '0;
            else rec_state_next = ctr_pkg::REC_STOP;
            if (cfg_full == ctr_pkg::FULL_HALT) halt_next = 1'b1;
          end
        end
      end
      ctr_pkg::REC_STOP: ;
      default: rec_state_next = ctr_pkg::REC_IDLE;
    endcase
    if (fire && !cfg_act_out) halt_next = 1'b1;
    if (do_restart) begin
      rec_state_next = ctr_pkg::REC_IDLE;
      wr_ptr_next = '0;
      full_next = 1'b0;
      halt_next = fire && !cfg_act_out;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rec_state_reg <= ctr_pkg::REC_IDLE;
      wr_ptr_reg <= '0;
      full_reg <= 1'b0;
      halt_reg <= 1'b0;
      mon_win_reg <= 1'b0;
      fired_reg <= 1'b0;
    end else if (clk_en) begin
      rec_state_reg <= rec_state_next;
      wr_ptr_reg <= wr_ptr_next;
      full_reg <= full_next;
      halt_reg <= halt_next;
      mon_win_reg <= mon_win_next;
      fired_reg <= fired_next;
    end
  end

  // Sample memory, no reset so it maps to RAM
  always_ff @(posedge mclk) begin
    if (clk_en && rec_write) mem[wr_ptr_reg] <= smp_reg[SW-1:0];
  end
  assign target_halt = halt_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_bus_answer: assert property ((avs_read || avs_write) && wait_reg && clk_en
    |=> !avs_waitrequest) else $error("waitrequest not released after one cycle");
  a_bus_single: assert property (!avs_waitrequest && clk_en |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wrap_restart: assert property (rec_write && ptr_last && clk_en && !do_restart
    && cfg_full == ctr_pkg::FULL_WRAP && cfg_run |=> wr_ptr_reg == '0
    && rec_state_reg == ctr_pkg::REC_RUN) else $error("wrap did not restart");
  a_stop_record: assert property (rec_write && ptr_last && clk_en && !do_restart
    && cfg_full == ctr_pkg::FULL_STOP |=> rec_state_reg == ctr_pkg::REC_STOP
    ##1 !rec_write) else $error("recording went on after full");
  a_halt_full: assert property (rec_write && ptr_last && clk_en && !do_restart
    && cfg_full == ctr_pkg::FULL_HALT |=> target_halt
    && rec_state_reg == ctr_pkg::REC_STOP) else $error("no halt on full");
  a_ext_gate: assert property (rec_write && cfg_acq == ctr_pkg::ACQ_EXT
    |-> ext_trig_in[ctrl_reg[`CTR_C_ICH]] == ctrl_reg[`CTR_C_ILVL])
    else $error("sample stored outside external gate");
  a_trig_off: assert property (!cfg_ten |-> !fire && !hold_next)
    else $error("trigger acted while disabled");
  a_halt_act: assert property (fire && !cfg_act_out && clk_en && !do_restart
    |=> target_halt) else $error("halt action missing");
  a_pulse_start: assert property (fire && cfg_act_out && cfg_pulse && clk_en
    |=> ext_trig_out[och_reg] && pulse_reg != 32'h0000_0000)
    else $error("pulse did not start");
  // Within qualifier fires on the first failing sample, so it is left out here
  a_over_level: assert property (fire && cfg_cond == ctr_pkg::CND_OVER
    && !(cfg_qen && cfg_qwithin) |-> smp_reg >= cfg_lo)
    else $error("over trigger below threshold");
  a_under_level: assert property (fire && cfg_cond == ctr_pkg::CND_UNDER
    && !(cfg_qen && cfg_qwithin) |-> smp_reg <= cfg_lo)
    else $error("under trigger above threshold");

  c_wrap: cover property (rec_write && ptr_last && cfg_full == ctr_pkg::FULL_WRAP);
  c_halt: cover property (fire && !cfg_act_out);
  c_pulse: cover property (fire && cfg_act_out && cfg_pulse);
  c_mon_rec: cover property (rec_write && cfg_acq == ctr_pkg::ACQ_MON);
endmodule // ctr_recorder
`default_nettype wire

//--- ctr_target_model.sv
// Purpose: sensor, target program and trigger equipment around the recorder
// Assumes: one clock; the bench sets the supply level
// Notes: reports the last high width seen on each trigger output
`timescale 1ns/1ps
`default_nettype none
module ctr_target_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Bench side
  input wire logic [15:0] cur_level,
  output logic [15:0] width_zero,
  output logic [15:0] width_one,
  output logic [31:0] run_cycles,
  // Recorder side
  input wire logic [1:0] ext_trig_out,
  input wire logic target_halt,
  output logic [15:0] cur_value
);
  logic [15:0] cnt_zero;
  logic [15:0] cnt_one;
  // ****************************************
  // Sensor, program and meters
  // ****************************************
  // Sensor settles one cycle late, so a level never changes at capture
  always_ff @(posedge mclk) begin
    cur_value <= cur_level;
  end
  // Program advances unless halted; meters latch width on each fall
  always_ff @(posedge mclk) begin
    if (srst) begin
      run_cycles <= 32'h0;
      cnt_zero <= 16'h0;
      cnt_one <= 16'h0;
      width_zero <= 16'h0;
      width_one <= 16'h0;
    end else begin
      if (!target_halt) begin
        run_cycles <= run_cycles + 32'h1;
      end
      if (ext_trig_out[0]) begin
        cnt_zero <= cnt_zero + 16'h1;
      end else if (cnt_zero != 16'h0) begin
        width_zero <= cnt_zero;
        cnt_zero <= 16'h0;
      end
      if (ext_trig_out[1]) begin
        cnt_one <= cnt_one + 16'h1;
      end else if (cnt_one != 16'h0) begin
        width_one <= cnt_one;
        cnt_one <= 16'h0;
      end
    end
  end
endmodule // ctr_target_model
`default_nettype wire

//--- ctr_recorder_test.sv
// Purpose: register-level bench for the current trigger recorder
// Assumes: CYC_PER_US of 1 and a four-word memory keep runs short
// Notes: tests are sequences of bus calls with expected values
`timescale 1ns/1ps
`default_nettype none
`include "ctr_regs.svh"
module ctr_recorder_test;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, sample_strobe, target_halt;
  logic mon_start = 1'b0;
  logic mon_end = 1'b0;
  logic [1:0] ext_trig_out;
  logic [1:0] ext_trig_in = 2'h0;
  logic [15:0] cur_level = 16'h0;
  logic [15:0] cur_value, width_zero, width_one;
  logic [31:0] run_cycles, rd, rc;
  logic [15:0] lv [6];
  logic [3:0] gate [6];
  logic [15:0] tbl [4][6];
  logic [31:0] per_us [10];
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  // ****************************************
  // Design, partner and clock
  // ****************************************
  ctr_recorder #(.DEPTH(4), .SW(16), .CYC_PER_US(1)) DUT (
    .mclk(mclk), .srst(srst), .clk_en(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cur_value(cur_value), .sample_strobe(sample_strobe), .ext_trig_in(ext_trig_in),
    .mon_start(mon_start), .mon_end(mon_end), .target_halt(target_halt),
    .ext_trig_out(ext_trig_out));
  ctr_target_model u_model (
    .mclk(mclk), .srst(srst), .cur_level(cur_level), .width_zero(width_zero),
    .width_one(width_one), .run_cycles(run_cycles), .ext_trig_out(ext_trig_out),
    .target_halt(target_halt), .cur_value(cur_value));
  // Free-running clock, 100 ns
  always #50 mclk = ~mclk;
  // Hang guard, well above the longest run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      print_verdict();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One Avalon cycle; entered just after an edge, leaves one idle edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge mclk);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic memchk(input logic [31:0] i, input logic [31:0] exp);
    bus(1'b1, `CTR_OFS_MADDR, i);
    rdchk(`CTR_OFS_MDATA, exp);
  endtask
  task automatic wait_strobe(output int cnt);
    cnt = 0;
    do begin
      @(posedge mclk);
      cnt++;
    end while (sample_strobe !== 1'b1 && cnt < 3000);
  endtask
  // Rising supply, no gating inputs
  task automatic ramp;
    for (int k = 0; k < 6; k++) begin
      lv[k] = 16'h64 + 16'(k);
      gate[k] = 4'h0;
    end
  endtask
  // Six samples at 10 us; fired flag read after each one
  task automatic run_seq(input logic [31:0] ctrl, input int fire_at);
    int w;
    cur_level <= lv[0];
    ext_trig_in <= gate[0][1:0];
    mon_start <= gate[0][2];
    mon_end <= gate[0][3];
    bus(1'b1, `CTR_OFS_CMD, 32'h3);
    bus(1'b1, `CTR_OFS_CTRL, ctrl | 32'h0004_0000);
    for (int k = 0; k < 6; k++) begin
      wait_strobe(w);
      cur_level <= lv[(k + 1) % 6];
      ext_trig_in <= gate[(k + 1) % 6][1:0];
      mon_start <= gate[(k + 1) % 6][2];
      mon_end <= gate[(k + 1) % 6][3];
      bus(1'b0, `CTR_OFS_STATUS, 32'h0);
      check({31'h0, rd[`CTR_S_FIRED]}, {31'h0, k >= fire_at});
    end
    bus(1'b1, `CTR_OFS_CTRL, 32'h0000_000c);
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    per_us = '{32'h1, 32'h2, 32'h5, 32'ha, 32'h14, 32'h32, 32'h64, 32'hc8, 32'h1f4, 32'h3e8};
    tbl = '{'{16'h64, 16'h64, 16'hc8, 16'hc8, 16'h64, 16'h64},
            '{16'hfa, 16'hfa, 16'hc8, 16'hc8, 16'hfa, 16'hfa},
            '{16'h64, 16'h64, 16'hfa, 16'hfa, 16'h64, 16'h64},
            '{16'hfa, 16'hfa, 16'h15e, 16'h15e, 16'hfa, 16'hfa}};
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    check({30'h0, ext_trig_out}, 32'h0);
    rdchk(`CTR_OFS_CTRL, `CTR_CTRL_RST);
    rdchk(`CTR_OFS_LEVELS, `CTR_LEVELS_RST);
    rdchk(`CTR_OFS_TIMING, `CTR_TIMING_RST);
    bus(1'b1, `CTR_OFS_STATUS, 32'hffff_ffff);
    rdchk(`CTR_OFS_STATUS, 32'h0);
    bus(1'b1, 5'h1c, 32'hffff_ffff);
    rdchk(5'h1c, 32'h0);
    $display("test reset done");
    for (int p = 0; p < 10; p++) begin
      bus(1'b1, `CTR_OFS_CTRL, 32'h0004_0000 | (32'(p) << 2));
      wait_strobe(n);
      wait_strobe(n);
      check(32'(n), per_us[p]);
    end
    bus(1'b1, `CTR_OFS_CTRL, 32'h0000_000c);
    $display("test periods done");
    for (int f = 0; f < 3; f++) begin
      ramp();
      run_seq(32'h0000_000c | 32'(f), 6);
      bus(1'b0, `CTR_OFS_STATUS, 32'h0);
      check({31'h0, rd[`CTR_S_FULL]}, 32'h1);
      check({31'h0, rd[`CTR_S_HALT]}, {31'h0, f == 2});
      if (f == 0) check({16'h0, rd[15:0]}, 32'h2);
      memchk(32'h0, (f == 0) ? 32'h68 : 32'h64);
      memchk(32'h3, 32'h67);
      rc = run_cycles;
      repeat (4) @(posedge mclk);
      check(run_cycles - rc, (f == 2) ? 32'h0 : 32'h4);
      bus(1'b1, `CTR_OFS_CMD, 32'h1);
      check({31'h0, target_halt}, 32'h0);
    end
    $display("test full modes done");
    for (int g = 0; g < 4; g++) begin
      ramp();
      for (int k = 0; k < 6; k++) begin
        gate[k][g / 2] = (k == 1 || k == 2) ? g[0] : !g[0];
        gate[k][1 - g / 2] = g[0];
      end
      run_seq(32'h0000_004c | (32'(g / 2) << 8) | (32'(g % 2) << 9), 6);
      rdchk(`CTR_OFS_STATUS, 32'h0001_0002 & 32'h0000_ffff | 32'h2);
      memchk(32'h0, 32'h65);
    end
    ramp();
    gate[1] = 4'h4;
    gate[3] = 4'h8;
    run_seq(32'h0000_008c, 6);
    bus(1'b0, `CTR_OFS_STATUS, 32'h0);
    check({16'h0, rd[15:0]}, 32'h2);
    memchk(32'h1, 32'h66);
    $display("test gating done");
    ramp();
    bus(1'b1, `CTR_OFS_LEVELS, 32'h012c_00c8);
    for (int c = 0; c < 4; c++) begin
      lv = tbl[c];
      bus(1'b1, `CTR_OFS_TIMING, 32'h0000_0001 + 32'(c));
      run_seq(32'h0000_2c0c | (32'(c) << 14), 2);
      check({16'h0, width_zero}, 32'h1 + 32'(c));
    end
    lv = tbl[0];
    run_seq(32'h0000_280c, 6);
    check({16'h0, width_one}, 32'h0);
    lv = '{16'h64, 16'hfa, 16'hfa, 16'h64, 16'h64, 16'h64};
    run_seq(32'h0000_1c0c, 1);
    check({16'h0, width_one}, 32'h14);
    check({16'h0, width_zero}, 32'h4);
    lv = tbl[0];
    run_seq(32'h0000_040c, 2);
    check({31'h0, target_halt}, 32'h1);
    bus(1'b1, `CTR_OFS_CMD, 32'h1);
    $display("test trigger done");
    lv = '{16'hfa, 16'hfa, 16'h64, 16'hfa, 16'hfa, 16'hfa};
    bus(1'b1, `CTR_OFS_TIMING, 32'h0003_0001);
    run_seq(32'h0001_2c0c, 5);
    lv = '{16'hfa, 16'hfa, 16'hfa, 16'h64, 16'hfa, 16'h64};
    bus(1'b1, `CTR_OFS_TIMING, 32'h0002_0001);
    run_seq(32'h0003_2c0c, 5);
    $display("test qualifier done");
    print_verdict();
  end
endmodule // ctr_recorder_test
`default_nettype wire
